// [logic/boot_cmd_defs.vh]
// Constants for the boot command responder
`ifndef BOOT_CMD_DEFS_VH
`define BOOT_CMD_DEFS_VH

`define CMD_RAM_XFER 8'h10
`define CMD_FLASH_SUM 8'h20
`define CMD_PROD_INFO 8'h30

`define ACK_RX_ERR 4'h8
`define ACK_BAD_CMD 4'h1
`define PREV_CMD_RST 4'h0

`define FLASH_BYTES 524288
`define FLASH_ADDR_W 19
`define SW_ID_ADDR 32'h000003F0
`define SW_ID_LEN 6'h04
`define INFO_LAST 6'h3D

`define PW_AREA_ADDR 32'h000003F4
`define RAM_START 32'hFFFD6000
`define INFO_DUMMY 32'hFFFD6FFF
`define RAM_END 32'hFFFDFFFF
`define INFO_CONST_A 32'hFFFD7000
`define INFO_CONST_B 32'hFFFDEFFF
`define CAP_WORD 16'h0001
`define FLASH_START 32'h00000000
`define FLASH_END 32'h000FFFFF
`define FLASH_BLOCKS 16'h0008
`define GRP_START 32'h00000000
`define GRP_SIZE_HW 32'h00010000
`define GRP_COUNT 8'h08

`endif

// [logic/boot_cmd_responder.v]
// Boot-mode responder for the flash sum and product information commands
`timescale 1ns/1ps
`default_nettype none
`include "boot_cmd_defs.vh"

module boot_cmd_responder #(
  parameter FLASH_BYTES = `FLASH_BYTES,
  parameter ADDR_W = `FLASH_ADDR_W,
  parameter [95:0] PRODUCT_NAME = "DEVPART0    "
) (
  input wire mclk,
  input wire nrst,
  input wire cmd_enable,
  input wire io_mode,
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_err,
  output wire tx_valid,
  input wire tx_ready,
  output wire [7:0] tx_data,
  output wire flash_rd_en,
  output wire [ADDR_W-1:0] flash_rd_addr,
  input wire [7:0] flash_rd_data,
  output wire ram_xfer_start,
  output wire busy
);

  // PRODUCT_NAME default value is arbitrary

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_PUSH = 3'h1;
  localparam [2:0] S_SUM = 3'h2;
  localparam [2:0] S_SUM_LO = 3'h3;
  localparam [2:0] S_WAIT_CK = 3'h4;
  localparam [2:0] S_INFO = 3'h5;
  localparam [2:0] S_FETCH = 3'h6;
  localparam [2:0] S_RAM_GO = 3'h7;

  // Reset release synchroniser
  reg rst_meta_reg;
  reg rst_n_reg;
  wire rst_n;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  assign rst_n = rst_n_reg;

  // State and datapath registers
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [2:0] ret_reg;
  reg [2:0] ret_next;
  reg [7:0] byte_reg;
  reg [7:0] byte_next;
  reg [3:0] prev_hi_reg;
  reg [3:0] prev_hi_next;
  reg [ADDR_W:0] cnt_reg;
  reg [ADDR_W:0] cnt_next;
  reg [15:0] acc_reg;
  reg [15:0] acc_next;
  reg [7:0] csum_reg;
  reg [7:0] csum_next;
  reg [5:0] idx_reg;
  reg [5:0] idx_next;
  reg rd_en_reg;
  reg rd_en_next;
  reg [ADDR_W-1:0] rd_addr_reg;
  reg [ADDR_W-1:0] rd_addr_next;
  reg rd_q_reg;

  // Buffer side signals
  reg push_valid;
  wire push_ready;

  // Constant part of the information reply, first byte in the low lane
  wire [95:0] name_lsb_first;
  wire [455:0] info_tab;
  wire [5:0] tab_k;
  wire [7:0] tab_byte;

  genvar g;
  generate
    for (g = 0; g < 12; g = g + 1) begin : name_rev
      assign name_lsb_first[g*8 +: 8] = PRODUCT_NAME[(11-g)*8 +: 8];
    end
  endgenerate

  // Words sit low byte first in the table, so each goes out LSB first
  assign info_tab = {
    `GRP_COUNT,
    `GRP_SIZE_HW,
    `GRP_START,
    `FLASH_BLOCKS,
    `FLASH_END,
    `FLASH_START,
    `CAP_WORD,
    `INFO_CONST_B,
    `INFO_CONST_A,
    `RAM_END,
    `INFO_DUMMY,
    `RAM_START,
    `PW_AREA_ADDR,
    name_lsb_first
  };

  assign tab_k = idx_reg - `SW_ID_LEN;
  assign tab_byte = info_tab[tab_k*8 +: 8];

  // Identifier address kept full width, then cut to the flash port
  wire [31:0] sw_id_rd_addr;
  assign sw_id_rd_addr = `SW_ID_ADDR + {26'h0000000, idx_reg};

  // Command answer decode
  reg [7:0] ack_code;
  wire rx_bad;
  wire cmd_take;

  assign rx_bad = rx_err & ~io_mode;
  assign cmd_take = rx_valid & cmd_enable & (state_reg == S_IDLE);

  always @* begin
    ack_code = {prev_hi_reg, `ACK_BAD_CMD};
    if (rx_bad) begin
      ack_code = {prev_hi_reg, `ACK_RX_ERR};
    end else begin
      case (rx_data)
        `CMD_RAM_XFER: ack_code = rx_data;
        `CMD_FLASH_SUM: ack_code = rx_data;
        `CMD_PROD_INFO: ack_code = rx_data;
        default: ack_code = {prev_hi_reg, `ACK_BAD_CMD};
      endcase
    end
  end

  // Main sequencer
  always @* begin
    state_next = state_reg;
    ret_next = ret_reg;
    byte_next = byte_reg;
    prev_hi_next = prev_hi_reg;
    cnt_next = cnt_reg;
    acc_next = acc_reg;
    csum_next = csum_reg;
    idx_next = idx_reg;
    rd_en_next = 1'b0;
    rd_addr_next = rd_addr_reg;
    push_valid = 1'b0;
    case (state_reg)
      S_IDLE: begin
        if (cmd_take) begin
          byte_next = ack_code;
          state_next = S_PUSH;
          ret_next = S_IDLE;
          if (!rx_bad) begin
            prev_hi_next = rx_data[7:4];
            case (rx_data)
              `CMD_FLASH_SUM: begin
                ret_next = S_SUM;
                cnt_next = {(ADDR_W+1){1'b0}};
                acc_next = 16'h0000;
              end
              `CMD_PROD_INFO: begin
                ret_next = S_INFO;
                idx_next = 6'h00;
                csum_next = 8'h00;
              end
              `CMD_RAM_XFER: begin
                ret_next = S_RAM_GO;
              end
              default: begin
                ret_next = S_IDLE;
              end
            endcase
          end
        end
      end
      S_PUSH: begin
        push_valid = 1'b1;
        if (push_ready) begin
          state_next = ret_reg;
          if (ret_reg == S_INFO) begin
            if (idx_reg != 6'h00 || csum_reg != 8'h00) begin
              csum_next = csum_reg + byte_reg;
              idx_next = idx_reg + 6'h01;
            end
          end
        end
      end
      S_SUM: begin
        // One read per cycle; data lands two cycles after the decision
        if (cnt_reg < FLASH_BYTES) begin
          rd_en_next = 1'b1;
          rd_addr_next = cnt_reg[ADDR_W-1:0];
          cnt_next = cnt_reg + 1'b1;
        end
        if (rd_q_reg) begin
          acc_next = acc_reg + {8'h00, flash_rd_data};
        end
        if (cnt_reg == FLASH_BYTES && !rd_en_reg && !rd_q_reg) begin
          byte_next = acc_reg[15:8];
          ret_next = S_SUM_LO;
          state_next = S_PUSH;
        end
      end
      S_SUM_LO: begin
        byte_next = acc_reg[7:0];
        ret_next = S_WAIT_CK;
        state_next = S_PUSH;
      end
      S_WAIT_CK: begin
        // Checksum byte from the controller is taken and not checked
        if (rx_valid) begin
          state_next = S_IDLE;
        end
      end
      S_INFO: begin
        if (idx_reg > `INFO_LAST) begin
          state_next = S_IDLE;
        end else if (idx_reg < `SW_ID_LEN) begin
          rd_en_next = 1'b1;
          rd_addr_next = sw_id_rd_addr[ADDR_W-1:0];
          state_next = S_FETCH;
        end else if (idx_reg == `INFO_LAST) begin
          byte_next = 8'h00 - csum_reg;
          ret_next = S_INFO;
          state_next = S_PUSH;
        end else begin
          byte_next = tab_byte;
          ret_next = S_INFO;
          state_next = S_PUSH;
        end
      end
      S_FETCH: begin
        if (rd_q_reg) begin
          byte_next = flash_rd_data;
          ret_next = S_INFO;
          state_next = S_PUSH;
        end
      end
      S_RAM_GO: begin
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // A reply byte of the info stream is counted even when it is zero
  reg info_first_reg;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      ret_reg <= S_IDLE;
      byte_reg <= 8'h00;
      prev_hi_reg <= `PREV_CMD_RST;
      cnt_reg <= {(ADDR_W+1){1'b0}};
      acc_reg <= 16'h0000;
      csum_reg <= 8'h00;
      idx_reg <= 6'h00;
      rd_en_reg <= 1'b0;
      rd_addr_reg <= {ADDR_W{1'b0}};
      rd_q_reg <= 1'b0;
      info_first_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ret_reg <= ret_next;
      byte_reg <= byte_next;
      prev_hi_reg <= prev_hi_next;
      cnt_reg <= cnt_next;
      acc_reg <= acc_next;
      rd_en_reg <= rd_en_next;
      rd_addr_reg <= rd_addr_next;
      rd_q_reg <= rd_en_reg;
      if (state_reg == S_PUSH && push_ready && ret_reg == S_INFO) begin
        // Echo of 30H is not part of the checksummed range
        if (info_first_reg) begin
          csum_reg <= csum_reg + byte_reg;
          idx_reg <= idx_reg + 6'h01;
        end
        info_first_reg <= 1'b1;
      end else begin
        // Hold the running sum while a full buffer stalls the push
        csum_reg <= (state_reg == S_PUSH) ? csum_reg : csum_next;
        idx_reg <= (state_reg == S_PUSH) ? idx_reg : idx_next;
        if (state_reg == S_IDLE) begin
          info_first_reg <= 1'b0;
        end
      end
    end
  end

  // Output buffer absorbs a transmitter stall without losing a byte
  tx_two_entry_buffer #(
    .WIDTH(8)
  ) u_tx_buf (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(byte_reg),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );

  assign flash_rd_en = rd_en_reg;
  assign flash_rd_addr = rd_addr_reg;
  assign ram_xfer_start = (state_reg == S_RAM_GO);
  assign busy = (state_reg != S_IDLE);

endmodule
`default_nettype wire

// [logic/tx_two_entry_buffer.v]
// Two-entry buffer between the responder and the serial transmitter
`timescale 1ns/1ps
`default_nettype none

module tx_two_entry_buffer #(
  parameter WIDTH = 8
) (
  input wire mclk,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] head_reg;
  reg [WIDTH-1:0] tail_reg;
  reg [1:0] count_reg;
  wire push;
  wire pop;

  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data = head_reg;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Head always holds the oldest word so the output comes from a flop
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      head_reg <= {WIDTH{1'b0}};
      tail_reg <= {WIDTH{1'b0}};
      count_reg <= 2'h0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (count_reg == 2'h0) begin
            head_reg <= in_data;
          end else begin
            tail_reg <= in_data;
          end
          count_reg <= count_reg + 2'h1;
        end
        2'b01: begin
          head_reg <= tail_reg;
          count_reg <= count_reg - 2'h1;
        end
        2'b11: begin
          if (count_reg == 2'h1) begin
            head_reg <= in_data;
          end else begin
            head_reg <= tail_reg;
            tail_reg <= in_data;
          end
        end
        default: begin
          count_reg <= count_reg;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// [sim/boot_cmd_responder_assertions.sv]
// Port checker for the boot command responder
`timescale 1ns/1ps
`default_nettype none
module boot_cmd_checker #(
  parameter FLASH_BYTES = 8,
  parameter ADDR_W = 19
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic cmd_enable,
  input wire logic io_mode,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_err,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic flash_rd_en,
  input wire logic [ADDR_W-1:0] flash_rd_addr,
  input wire logic busy
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  wire logic take = rx_valid && cmd_enable && !busy;
  wire logic ok = take && !(rx_err && !io_mode);
  logic [3:0] prev_hi;
  logic sum_mode;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prev_hi <= 4'h0;
      sum_mode <= 1'b0;
    end else begin
      if (ok)
        prev_hi <= rx_data[7:4];
      sum_mode <= (ok && rx_data == 8'h20) || (sum_mode && busy);
    end
  end
  // Empty buffer gives a fixed two-cycle answer slot
  property p_echo_sum;
    ok && !tx_valid && rx_data == 8'h20 |-> ##2 tx_valid && tx_data == 8'h20;
  endproperty
  a_echo_sum: assert property (p_echo_sum) else $error("sum echo wrong");
  property p_echo_info;
    ok && !tx_valid && rx_data == 8'h30 |-> ##2 tx_valid && tx_data == 8'h30;
  endproperty
  a_echo_info: assert property (p_echo_info) else $error("info echo wrong");
  property p_rx_err;
    take && !tx_valid && rx_err && !io_mode |-> ##2 tx_data == {$past(prev_hi, 2), 4'h8};
  endproperty
  a_rx_err: assert property (p_rx_err) else $error("rx error code wrong");
  property p_bad_cmd;
    ok && !tx_valid && rx_data != 8'h10 && rx_data != 8'h20 && rx_data != 8'h30
      |-> ##2 tx_valid && tx_data == {$past(prev_hi, 2), 4'h1};
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("bad command code wrong");
  property p_io_no_err;
    take && !tx_valid && io_mode && rx_err |-> ##2 tx_valid && !tx_data[3];
  endproperty
  a_io_no_err: assert property (p_io_no_err) else $error("io mode flagged error");
  property p_sum_start;
    ok && rx_data == 8'h20 |-> ##[1:8] flash_rd_en && flash_rd_addr == 0;
  endproperty
  a_sum_start: assert property (p_sum_start) else $error("sum not from zero");
  property p_sum_step;
    sum_mode && flash_rd_en && flash_rd_addr != FLASH_BYTES - 1
      |=> flash_rd_en && flash_rd_addr == $past(flash_rd_addr) + 1'b1;
  endproperty
  a_sum_step: assert property (p_sum_step) else $error("sum read skipped");
  property p_info_id;
    ok && rx_data == 8'h30 |-> ##[1:20] flash_rd_en && flash_rd_addr == 32'h000003F0;
  endproperty
  a_info_id: assert property (p_info_id) else $error("id read missing");
  property p_ignored;
    rx_valid && !cmd_enable && !busy |=> !busy;
  endproperty
  a_ignored: assert property (p_ignored) else $error("byte taken while off");
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_hold: assert property (p_hold) else $error("reply byte lost");
endmodule
bind boot_cmd_responder boot_cmd_checker #(.FLASH_BYTES(FLASH_BYTES), .ADDR_W(ADDR_W)) chk_u (
  .mclk(mclk),
  .nrst(nrst),
  .cmd_enable(cmd_enable),
  .io_mode(io_mode),
  .rx_valid(rx_valid),
  .rx_data(rx_data),
  .rx_err(rx_err),
  .tx_valid(tx_valid),
  .tx_ready(tx_ready),
  .tx_data(tx_data),
  .flash_rd_en(flash_rd_en),
  .flash_rd_addr(flash_rd_addr),
  .busy(busy)
);
`default_nettype wire

// [sim/boot_cmd_responder_tb.sv]
// Self-checking bench for the boot command responder
`timescale 1ns/1ps
`default_nettype none
module boot_cmd_responder_tb;
  localparam N = 600;
  localparam [95:0] name = "DEVPART0    ";
  localparam [359:0] tbl = {32'hF4030000, 32'h0060FDFF, 32'hFF6FFDFF, 32'hFFFFFDFF,
    32'h0070FDFF, 32'hFFEFFDFF, 16'h0100, 32'h00000000, 32'hFFFF0F00, 16'h0800,
    32'h00000000, 32'h00000100, 8'h08};
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic cmd_enable = 1'b1;
  logic io_mode = 1'b0;
  logic rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic rx_err = 1'b0;
  logic tx_ready = 1'b0;
  logic tx_valid, flash_rd_en, busy, ram_xfer_start;
  integer n_xfer = 0;
  logic [7:0] tx_data, fl_data;
  logic [18:0] fl_addr;
  integer fails = 0;
  integer n_checks = 0;
  integer stall = 0;
  always #25 mclk = ~mclk;
  boot_cmd_responder #(.FLASH_BYTES(N)) dut_u (.mclk(mclk), .nrst(nrst),
    .cmd_enable(cmd_enable), .io_mode(io_mode), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_err(rx_err), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .flash_rd_en(flash_rd_en), .flash_rd_addr(fl_addr), .flash_rd_data(fl_data),
    .ram_xfer_start(ram_xfer_start), .busy(busy));
  flash_model flash_u (.mclk(mclk), .rd_en(flash_rd_en), .rd_addr(fl_addr), .rd_data(fl_data));
  always @(posedge mclk) if (ram_xfer_start === 1'b1) n_xfer <= n_xfer + 1;
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // Alternate stalls so the two-entry buffer fills up
  task get(input [7:0] exp);
    begin
      @(negedge mclk);
      while (tx_valid !== 1'b1) @(negedge mclk);
      stall = 3 - stall;
      repeat (stall) @(negedge mclk);
      n_checks = n_checks + 1;
      if (tx_data !== exp) begin
        fails = fails + 1;
        $display("unexpected tx_data: expected %h, seen %h", exp, tx_data);
      end
      @(posedge mclk) tx_ready <= 1'b1;
      @(posedge mclk) tx_ready <= 1'b0;
    end
  endtask
  task send(input [7:0] d, input e);
    begin
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_data <= d;
      rx_err <= e;
      @(posedge mclk) rx_valid <= 1'b0;
    end
  endtask
  task wait_idle;
    begin
      @(negedge mclk);
      while (busy !== 1'b0 || tx_valid !== 1'b0) @(negedge mclk);
    end
  endtask
  task t_sum;
    integer k;
    logic [15:0] s;
    begin
      s = 16'h0000;
      for (k = 0; k < N; k = k + 1)
        s = s + {8'h00, k[7:0] + 8'hA1};
      wait_idle;
      send(8'h20, 1'b0);
      get(8'h20);
      get(s[15:8]);
      get(s[7:0]);
      send(8'h00 - s[15:8] - s[7:0], 1'b0);
    end
  endtask
  task t_info;
    integer k;
    logic [7:0] b, s;
    begin
      wait_idle;
      send(8'h30, 1'b0);
      get(8'h30);
      s = 8'h00;
      for (k = 0; k < 61; k = k + 1) begin
        if (k < 4)
          b = 8'h91 + k[7:0];
        else if (k < 16)
          b = name[95 - 8 * (k - 4) -: 8];
        else
          b = tbl[359 - 8 * (k - 16) -: 8];
        s = s + b;
        get(b);
      end
      get(8'h00 - s);
    end
  endtask
  task t_err;
    begin
      wait_idle;
      send(8'h20, 1'b1);
      get(8'h38);
      io_mode <= 1'b1;
      wait_idle;
      send(8'h55, 1'b1);
      get(8'h31);
      io_mode <= 1'b0;
      wait_idle;
      send(8'h77, 1'b0);
      get(8'h51);
      wait_idle;
      send(8'h10, 1'b0);
      get(8'h10);
      wait_idle;
      n_checks = n_checks + 1;
      if (n_xfer != 1) begin
        fails = fails + 1;
        $display("unexpected ram_xfer_start pulses: expected 1, seen %0d", n_xfer);
      end
    end
  endtask
  task t_off;
    integer k;
    begin
      wait_idle;
      @(posedge mclk) cmd_enable <= 1'b0;
      send(8'h30, 1'b0);
      for (k = 0; k < 20; k = k + 1) begin
        @(negedge mclk);
        n_checks = n_checks + 1;
        if (busy !== 1'b0 || tx_valid !== 1'b0) begin
          fails = fails + 1;
          $display("unexpected busy: expected 0, seen %b", busy);
        end
      end
      @(posedge mclk) cmd_enable <= 1'b1;
    end
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    t_sum;
    t_info;
    t_err;
    t_off;
    finish_test;
  end
  initial begin
    #3000000;
    fails = fails + 1;
    finish_test;
  end
endmodule
`default_nettype wire

// [sim/flash_model.sv]
// Flash array model seen by the responder's read port
`timescale 1ns/1ps
`default_nettype none
module flash_model (
  input wire logic mclk,
  input wire logic rd_en,
  input wire logic [18:0] rd_addr,
  output var logic [7:0] rd_data
);
  initial rd_data = 8'h00;
  // Data only valid the cycle after a read; it churns otherwise
  always @(posedge mclk) begin
    if (rd_en)
      rd_data <= rd_addr[7:0] + 8'hA1;
    else
      rd_data <= ~rd_data;
  end
endmodule
`default_nettype wire
